// >>> src/apd_audio_out.sv
`timescale 1ns/1ns
// Overview of operation
// RL1: Ten-bit uses extension bits 3:2 as low.
// RL2: Twelve-bit uses all four extension bits.
// RL3: Middle nibble maps per selected resolution.
// RL4: High nibble maps per selected resolution.
// RL5: High nibble bit three is sign.
// RL6: Eight-bit: bit seven sign, rest pulse length.
// RL7: Output cycles fixed at 32 kHz.
// RL8: Cycle end sets modulator interrupt flag.
// RL9: Reload sample at cycle end, else repeat.
// RL10: Software writes samples before enabling output.
// RL11: Output disabled drives both pins low.
// RL12: Halt clears enable, tri-states speaker pins.
// RL13: Control bit one interrupt, bit zero enable.
// RL14: Ten-bit magnitude range 0 to 511.
// RL15: Twelve-bit magnitude range 0 to 2047.
// RL16: Wake armed in halt holds pins grounded.
// RL17: Wake signal follows negative pin comparator.
// RL18: Software silences output before halting.
// RL19: Port wake option stays disabled meanwhile.
// RL20: Wake register: flag, select, enable.
// RL21: Software clears the modulator interrupt flag.
// RL22: Converter option reroutes data to converter.
// RL23: Sign chooses which pin pulses.
// RL24: Rising wake in halt sets flag, resumes.
module apd_audio_out
    import apd_pkg::*;
#(
    parameter apd_res_type RESOLUTION     = RES_8BIT,
    parameter logic        WAKE_OPTION    = 1'b1,
    parameter logic        CONVERTER_MODE = 1'b0
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [9:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_wake_compare,
    output logic             o_spk_pos,
    output logic             o_spk_pos_oe,
    output logic             o_spk_neg,
    output logic             o_spk_neg_oe,
    output logic             o_irq_request,
    output logic             o_halted,
    output logic             o_wake_resume,
    output logic      [11:0] o_converter_data,
    output logic             o_converter_load
);
    localparam int CW = $clog2(CYCLE_CLOCKS);
    localparam logic [CW-1:0] LAST_COUNT = CW'(CYCLE_CLOCKS - 1);

    typedef struct packed {
        logic [3:0]    control;
        logic [3:0]    wake_reg;
        logic          mod_flag;
        logic [3:0]    ext_nibble;
        logic [3:0]    mid_nibble;
        logic [3:0]    high_nibble;
        logic [11:0]   active_sample;
        logic [CW-1:0] cycle_count;
        logic          halted;
        logic          wake_prev;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic          spk_pos;
        logic          spk_pos_oe;
        logic          spk_neg;
        logic          spk_neg_oe;
        logic          irq;
        logic          resume;
        logic [11:0]   conv_data;
        logic          conv_load;
    } apd_state_type;

    apd_state_type state;
    apd_state_type next_state;
    logic          wake_level;
    logic          setup;
    logic          access_write;
    logic [7:0]    word_index;
    logic          mapped;
    logic          cycle_end;
    logic [11:0]   assembled;
    logic          sign;
    logic [10:0]   magnitude;
    logic          pulse_on;
    logic          wake_armed;
    logic          wake_rise;
    logic [3:0]    read_nibble;

    // The comparator output arrives from analog, so it is synchronised first.
    apd_sync u_wake_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_async   (i_wake_compare),
        .o_sync    (wake_level)
    );

    always_comb begin
        word_index   = i_paddr[9:WORD_SHIFT];
        setup        = i_psel && !i_penable;
        // A write lands only on the access edge at which the master sees ready.
        access_write = i_psel && i_penable && i_pwrite && state.pready;
        mapped       = (word_index == ADDR_STATUS) || (word_index == ADDR_EXTENSION)
                    || (word_index == ADDR_CONTROL) || (word_index == ADDR_MIDDLE)
                    || (word_index == ADDR_HIGH) || (word_index == ADDR_WAKE)
                    || (word_index == ADDR_HALT);
        cycle_end    = state.cycle_count == LAST_COUNT; // RL7
        sign         = state.active_sample[11]; // RL5
        unique case (RESOLUTION)
            RES_10BIT: begin
                assembled = {state.high_nibble, state.mid_nibble, // RL3 RL4
                             state.ext_nibble[3:2], 2'h0}; // RL1
                magnitude = {2'h0, state.active_sample[10:2]}; // RL14
            end
            RES_12BIT: begin
                assembled = {state.high_nibble, state.mid_nibble, // RL3 RL4
                             state.ext_nibble}; // RL2
                magnitude = state.active_sample[10:0]; // RL15
            end
            default: begin
                assembled = {state.high_nibble, state.mid_nibble, 4'h0}; // RL3 RL4
                magnitude = {4'h0, state.active_sample[10:4]}; // RL6
            end
        endcase
        // The count is compared in clock cycles; the longest magnitude, 2047, ends before the 3125-clock cycle end.
        pulse_on   = {{(32 - CW){1'b0}}, state.cycle_count} < {21'h0, magnitude};
        wake_armed = WAKE_OPTION && state.halted && state.wake_reg[WAKE_EN]; // RL16
        wake_rise  = wake_level && !state.wake_prev;
        unique case (word_index)
            ADDR_STATUS:  read_nibble = {1'b0, state.mod_flag, 2'h0};
            ADDR_CONTROL: read_nibble = {2'h0, state.control[1:0]}; // RL13
            ADDR_WAKE:    read_nibble = state.wake_reg; // RL20
            default:      read_nibble = 4'h0;
        endcase

        next_state           = state;
        next_state.wake_prev = wake_level;
        next_state.pready    = setup;
        next_state.pslverr   = setup && !mapped;
        next_state.prdata    = {28'h0, (setup && !i_pwrite) ? read_nibble : 4'h0};
        next_state.resume    = 1'b0;
        next_state.conv_load = 1'b0;

        if (state.control[CTRL_OUT_EN]) begin
            next_state.cycle_count = cycle_end ? '0 : state.cycle_count + 1'b1;
        end else begin
            next_state.cycle_count = '0;
        end

        if (access_write) begin
            unique case (word_index)
                ADDR_STATUS: begin
                    next_state.mod_flag = i_pwdata[STAT_MOD_FLAG]; // RL21
                end
                ADDR_EXTENSION: begin
                    next_state.ext_nibble = i_pwdata[3:0];
                end
                ADDR_CONTROL: begin
                    next_state.control = {2'h0, i_pwdata[CTRL_GIE], i_pwdata[CTRL_OUT_EN]}; // RL13
                end
                ADDR_MIDDLE: begin
                    next_state.mid_nibble = i_pwdata[3:0];
                end
                ADDR_HIGH: begin
                    next_state.high_nibble = i_pwdata[3:0];
                end
                ADDR_WAKE: begin
                    next_state.wake_reg[WAKE_SEL_HI:WAKE_EN] = i_pwdata[WAKE_SEL_HI:WAKE_EN];
                    if (!i_pwdata[WAKE_FLAG]) begin
                        next_state.wake_reg[WAKE_FLAG] = 1'b0; // RL20
                    end
                end
                ADDR_HALT: begin
                    if (i_pwdata[HALT_CMD]) begin
                        next_state.halted                = 1'b1;
                        next_state.control[CTRL_OUT_EN] = 1'b0; // RL12
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware sets win over a same-cycle software clear.
        if (state.control[CTRL_OUT_EN] && cycle_end) begin
            next_state.mod_flag      = 1'b1; // RL8
            next_state.active_sample = assembled; // RL9
            next_state.conv_data     = assembled;
            next_state.conv_load     = CONVERTER_MODE; // RL22
        end

        if (wake_armed && wake_rise) begin
            next_state.wake_reg[WAKE_FLAG] = 1'b1; // RL24
            next_state.halted              = 1'b0;
            next_state.resume              = 1'b1; // RL24
        end

        if (state.halted && !wake_armed) begin
            next_state.spk_pos    = 1'b0;
            next_state.spk_neg    = 1'b0;
            next_state.spk_pos_oe = 1'b0; // RL12
            next_state.spk_neg_oe = 1'b0;
        end else if (wake_armed) begin
            next_state.spk_pos    = 1'b0; // RL16
            next_state.spk_neg    = 1'b0;
            next_state.spk_pos_oe = 1'b1;
            next_state.spk_neg_oe = 1'b1;
        end else begin
            next_state.spk_pos_oe = 1'b1;
            next_state.spk_neg_oe = 1'b1;
            if (!state.control[CTRL_OUT_EN] || CONVERTER_MODE) begin
                next_state.spk_pos = 1'b0; // RL11 RL22
                next_state.spk_neg = 1'b0;
            end else begin
                next_state.spk_pos = pulse_on && !sign; // RL23
                next_state.spk_neg = pulse_on && sign; // RL23
            end
        end
        next_state.irq = next_state.mod_flag && next_state.control[CTRL_GIE];
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state          <= '0;
            state.control  <= CONTROL_RESET;
            state.wake_reg <= WAKE_RESET;
        end else begin
            state <= next_state;
        end
    end

    // The wake level feeds only the core's wake logic, never the bus.
    assign o_prdata         = state.prdata;
    assign o_pready         = state.pready;
    assign o_pslverr        = state.pslverr;
    assign o_spk_pos        = state.spk_pos;
    assign o_spk_pos_oe     = state.spk_pos_oe;
    assign o_spk_neg        = state.spk_neg;
    assign o_spk_neg_oe     = state.spk_neg_oe;
    assign o_irq_request    = state.irq;
    assign o_halted         = state.halted;
    assign o_wake_resume    = state.resume; // RL17
    assign o_converter_data = state.conv_data;
    assign o_converter_load = state.conv_load;
endmodule : apd_audio_out

// >>> src/apd_pkg.sv
package apd_pkg;
    // Register word addresses (printed offsets are not all multiples of four,
    // so the printed offset is an index and the byte address is four times it).
    localparam logic [7:0] ADDR_STATUS    = 8'h00;
    localparam logic [7:0] ADDR_EXTENSION = 8'h08;
    localparam logic [7:0] ADDR_CONTROL   = 8'h09;
    localparam logic [7:0] ADDR_MIDDLE    = 8'h0a;
    localparam logic [7:0] ADDR_HIGH      = 8'h0b;
    localparam logic [7:0] ADDR_WAKE      = 8'h12;
    localparam logic [7:0] ADDR_HALT      = 8'h20;
    localparam int         WORD_SHIFT     = 2;
    // Field positions.
    localparam int CTRL_OUT_EN    = 0;
    localparam int CTRL_GIE       = 1;
    localparam int STAT_MOD_FLAG  = 2;
    localparam int WAKE_EN        = 0;
    localparam int WAKE_SEL_LO    = 1;
    localparam int WAKE_SEL_HI    = 2;
    localparam int WAKE_FLAG      = 3;
    localparam int SIGN_BIT       = 3;
    localparam int HALT_CMD       = 0;
    // Reset values.
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [3:0] WAKE_RESET    = 4'h0;
    // Timing.
    localparam int CLK_HZ       = 100_000_000;
    localparam int SAMPLE_HZ    = 32_000;
    localparam int CYCLE_CLOCKS = CLK_HZ / SAMPLE_HZ;
    // Resolution modes.
    typedef enum logic [1:0] {
        RES_8BIT,
        RES_10BIT,
        RES_12BIT
    } apd_res_type;
endpackage : apd_pkg

// >>> src/apd_sync.sv
`timescale 1ns/1ns
module apd_sync (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_async,
    output logic      o_sync
);
    typedef struct packed {
        logic first;
        logic second;
    } apd_sync_type;

    apd_sync_type state;
    apd_sync_type next_state;

    // The first stage is only read by the second, to keep metastability contained.
    always_comb begin
        next_state.first  = i_async;
        next_state.second = state.first;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.second;
endmodule : apd_sync

// >>> bench/apd_properties.sv
`timescale 1ns/1ns
module apd_properties (
    input wire logic        i_sys_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        o_spk_pos,
    input wire logic        o_spk_pos_oe,
    input wire logic        o_spk_neg,
    input wire logic        o_spk_neg_oe,
    input wire logic        o_halted,
    input wire logic        o_wake_resume
);
    // Length of the current pulse on either pin.
    logic [11:0] high_count;
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            high_count <= 12'h000;
        end else begin
            high_count <= (o_spk_pos | o_spk_neg) ? high_count + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    ready_timing_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    ready_cause_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    error_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    data_upper_a: assert property (o_pready |-> o_prdata[31:4] == 28'h0)
        else $error("read data upper bits set");
    pins_exclusive_a: assert property (!(o_spk_pos && o_spk_neg))
        else $error("both pins pulse");
    halt_ground_a: assert property (o_halted |-> !o_spk_pos && !o_spk_neg)
        else $error("pin high in halt");
    halt_float_a: assert property (o_halted && !o_spk_pos_oe |-> !o_spk_neg_oe)
        else $error("one pin driven in halt");
    resume_pulse_a: assert property (o_wake_resume |=> !o_wake_resume)
        else $error("resume longer than one cycle");
    resume_halt_a: assert property (o_wake_resume |-> $past(o_halted))
        else $error("resume outside halt");
    pulse_length_a: assert property (high_count <= 12'h07f)
        else $error("pulse longer than seven bits");
endmodule : apd_properties

bind apd_audio_out apd_properties apd_properties_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_spk_pos(o_spk_pos), .o_spk_pos_oe(o_spk_pos_oe), .o_spk_neg(o_spk_neg),
    .o_spk_neg_oe(o_spk_neg_oe), .o_halted(o_halted), .o_wake_resume(o_wake_resume));

// >>> bench/apd_speaker_model.sv
`timescale 1ns/1ns
module apd_speaker_model (
    input wire logic i_spk_neg,
    input wire logic i_spk_neg_oe,
    input wire logic i_sound,
    output logic     o_wake_compare
);
    // A released pin sits near ground, so only received sound lifts it above the reference.
    // No port pin offers a second wake source here, so the speaker alone wakes the core.
    assign o_wake_compare = (i_spk_neg_oe & i_spk_neg) | i_sound;
endmodule : apd_speaker_model

// >>> bench/tb_apd_audio_out.sv
`timescale 1ns/1ns
module tb_apd_audio_out;
    import apd_pkg::*;
    typedef struct {logic [7:0] a; logic [3:0] d; logic [3:0] q; logic e;} apd_row_type;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er, sound, wake_compare;
    logic spk_pos, spk_pos_oe, spk_neg, spk_neg_oe, irq_request, halted, wake_resume, conv_load;
    logic [9:0]  paddr;
    logic [11:0] conv_data;
    logic [31:0] pwdata, prdata, rd;
    int errors, n_compared;
    apd_row_type rows[4] = '{'{ADDR_CONTROL, 4'he, 4'h2, 1'b0}, '{ADDR_WAKE, 4'h6, 4'h6, 1'b0},
                             '{8'h30, 4'h5, 4'h0, 1'b1}, '{ADDR_CONTROL, 4'h0, 4'h0, 1'b0}};
    apd_audio_out apd_audio_out_inst (.i_sys_clk(sys_clk), .i_reset(reset), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_wake_compare(wake_compare), .o_spk_pos(spk_pos), .o_spk_pos_oe(spk_pos_oe),
        .o_spk_neg(spk_neg), .o_spk_neg_oe(spk_neg_oe), .o_irq_request(irq_request),
        .o_halted(halted), .o_wake_resume(wake_resume), .o_converter_data(conv_data),
        .o_converter_load(conv_load));
    apd_speaker_model apd_speaker_model_inst (.i_spk_neg(spk_neg), .i_spk_neg_oe(spk_neg_oe),
        .i_sound(sound), .o_wake_compare(wake_compare));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {28'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits one whole cycle so the new sample is loaded, then sums pin time over one period.
    task automatic measure(input int np, input int nn);
        int p, n;
        p = 0;
        n = 0;
        repeat (CYCLE_CLOCKS) @(posedge sys_clk);
        repeat (CYCLE_CLOCKS) begin
            @(posedge sys_clk);
            p += int'(spk_pos === 1'b1);
            n += int'(spk_neg === 1'b1);
        end
        chk("positive width", np, p);
        chk("negative width", nn, n);
    endtask : measure
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        finish_test();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata, sound, errors, n_compared} = '0;
        reset = 1'b1;
        repeat (16) @(posedge sys_clk);
        chk("pins in reset", 0, {spk_pos_oe, spk_neg_oe, spk_pos, spk_neg});
        reset <= 1'b0;
        apb(0, ADDR_CONTROL, 0);
        chk("control reset", CONTROL_RESET, rd);
        apb(0, ADDR_WAKE, 0);
        chk("wake reset", WAKE_RESET, rd);
        foreach (rows[k]) begin
            apb(1, rows[k].a, rows[k].d);
            chk("write error", rows[k].e, er);
            apb(0, rows[k].a, 0);
            chk("read data", rows[k].q, rd);
        end
        apb(1, ADDR_HIGH, 4'h1);
        apb(1, ADDR_MIDDLE, 4'h4);
        apb(1, ADDR_CONTROL, 4'h3);
        measure(20, 0);
        chk("interrupt", 1, irq_request);
        apb(0, ADDR_STATUS, 0);
        chk("status flag", 4, rd & 32'h4);
        chk("converter data", 32'h140, conv_data);
        chk("converter load", 0, conv_load);
        apb(1, ADDR_STATUS, 4'h0);
        apb(0, ADDR_STATUS, 4'h0);
        chk("status cleared", 0, rd & 32'h4);
        apb(1, ADDR_HIGH, 4'h8);
        apb(1, ADDR_MIDDLE, 4'h5);
        measure(0, 5);
        measure(0, 5);
        apb(1, ADDR_CONTROL, 4'h2);
        measure(0, 0);
        apb(1, ADDR_HIGH, 4'h0);
        apb(1, ADDR_MIDDLE, 4'h0);
        apb(1, ADDR_WAKE, 4'h1);
        apb(1, ADDR_CONTROL, 4'h3);
        measure(0, 0);
        apb(1, ADDR_HALT, 4'h1);
        repeat (4) @(posedge sys_clk);
        chk("armed pins", 5'h15, {spk_pos_oe, spk_pos, spk_neg_oe, spk_neg, halted});
        sound <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (wake_resume === 1'b1) break;
        end
        chk("resume", 1, wake_resume);
        sound <= 1'b0;
        apb(0, ADDR_WAKE, 0);
        chk("wake flag", 4'h9, rd);
        apb(0, ADDR_CONTROL, 0);
        chk("enable cleared", 4'h2, rd);
        apb(1, ADDR_WAKE, 4'h0);
        apb(1, ADDR_HALT, 4'h1);
        repeat (4) @(posedge sys_clk);
        chk("released pins", 0, {spk_pos_oe, spk_neg_oe});
        finish_test();
    end
endmodule : tb_apd_audio_out
